// ==== lpa_defines.svh ====
/*
 * Constants of the sleep-mode, polling-select and analog monitor
 * configuration block: register addresses, field positions, reset
 * values and channel-code ranges.
 * Assumes it is included by its bare name from the package and the module.
 */
`ifndef LPA_DEFINES_SVH
`define LPA_DEFINES_SVH

// ==========================================================================
// Channel counts and frame layout.
// ==========================================================================
`define LPA_PROG_CH 8
`define LPA_GND_CH 14
`define LPA_ALL_CH 22
`define LPA_FRAME_BITS 6'd32
`define LPA_DATA_BITS 24
`define LPA_ADDR_BITS 7
`define LPA_CODE_BITS 6

// ==========================================================================
// Register addresses (7-bit frame address field).
// ==========================================================================
`define LPA_ADDR_PROG_POLL 7'h16
`define LPA_ADDR_GND_POLL 7'h17
`define LPA_ADDR_SLEEP 7'h1C
`define LPA_ADDR_ANALOG 7'h1D

// ==========================================================================
// Field positions and values.
// ==========================================================================
`define LPA_ANALOG_SRC_BIT 6
`define LPA_SLEEP_PATTERN 24'h000000
`define LPA_REG_RESET 24'h000000
`define LPA_CODE_NONE 6'h00
`define LPA_CODE_GND_FIRST 6'h01
`define LPA_CODE_GND_LAST 6'h0E
`define LPA_CODE_PROG_FIRST 6'h0F
`define LPA_CODE_PROG_LAST 6'h16

`endif

// ==== lpa_pkg.sv ====
/*
 * Types of the sleep-mode, polling-select and analog monitor block.
 * Assumes the defines header is on the include path.
 */
`include "lpa_defines.svh"

package lpa_pkg;

    // ======================================================================
    // Link phase, Gray coded along idle, shift, commit.
    // ======================================================================
    typedef enum logic [1:0] {
        LPA_IDLE = 2'b00,
        LPA_SHIFT = 2'b01,
        LPA_COMMIT = 2'b11
    } lpa_phase_t;

    // Received command frame, most significant bit first on the wire.
    typedef struct packed {
        logic [`LPA_ADDR_BITS-1:0] addr;
        logic wr;
        logic [`LPA_DATA_BITS-1:0] data;
    } lpa_frame_t;

    // Reply word: fault summary, event flag, register data.
    typedef struct packed {
        logic fault;
        logic event_flag;
        logic [`LPA_ALL_CH-1:0] data;
    } lpa_reply_t;

    // Software-visible configuration.
    typedef struct packed {
        logic [`LPA_PROG_CH-1:0] prog_poll;
        logic [`LPA_GND_CH-1:0] gnd_poll;
        logic analog_src;
        logic [`LPA_CODE_BITS-1:0] analog_code;
    } lpa_cfg_t;

    // Whole state of the block.
    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [2:0] cs_sync;
        logic [1:0] mosi_sync;
        lpa_phase_t phase;
        logic [5:0] bit_cnt;
        lpa_frame_t rx;
        logic [31:0] tx;
        lpa_reply_t reply_next;
        lpa_cfg_t cfg;
        logic sleep;
        logic wake_pend;
        logic [`LPA_ALL_CH-1:0] route;
        logic [`LPA_ALL_CH-1:0] poll_wet;
        logic analog_wet;
        logic miso;
        logic miso_oe_n;
    } lpa_state_t;

endpackage

// ==== lpa_config.sv ====
/*
 * Serial-link configuration block: per-channel sleep polling current
 * select, the sleep entry command and the analog monitor selector.
 * Assumes switch states, fault summary, event flag and wake request come
 * from logic on clk; the serial pins come from outside and are
 * synchronised here. Link is mode 0: clock idles low, data taken on the
 * rising edge, reply changes on the falling edge.
 */
// Functional notes
// - select 0 gives normal polling current.
// - select 1 gives wetting current when polling.
// - programmable select bits 7..0, reset zero.
// - ground select bits 13..0, reset zero.
// - only the sleep command enters sleep.
// - sleep keeps every configuration value.
// - sleep command: write, all data zero.
// - accepted sleep command starts sleep activities.
// - first reply after wake flags both set.
// - at most one of 22 inputs routed.
// - routed input reads zero in status.
// - analog select writable in normal mode.
// - code bits 5..0, source bit 6.
// - code 0 none, 1-14 ground, 15-22 programmable.
// - source bit 1 drives wetting current while an input is routed.
// - reply bit 23 fault, 22 event.
`timescale 1ns/10ps
`include "lpa_defines.svh"

module lpa_config
    import lpa_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic [`LPA_ALL_CH-1:0] switch_state,
    input wire logic fault_summary,
    input wire logic event_flag,
    input wire logic wake_request,
    output logic sleep_mode,
    output logic [`LPA_ALL_CH-1:0] poll_use_wetting,
    output logic [`LPA_ALL_CH-1:0] analog_route,
    output logic [`LPA_CODE_BITS-1:0] analog_code,
    output logic analog_wet_drive
);

    // ======================================================================
    // State and helpers.
    // ======================================================================
    lpa_state_t st_reg;
    lpa_state_t st_next;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic frame_ok;
    logic sleep_cmd_ok;
    logic [`LPA_ALL_CH-1:0] masked_state;
    logic [31:0] tx_load;

    // Map an analog channel code onto a route vector; undefined codes route
    // nothing, so a bad write can never connect two inputs at once.
    function automatic logic [`LPA_ALL_CH-1:0] route_of(
        input logic [`LPA_CODE_BITS-1:0] code
    );
        logic [`LPA_ALL_CH-1:0] r;
        r = '0;
        for (int i = 0; i < `LPA_ALL_CH; i++) begin
            if (code == `LPA_CODE_BITS'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // ======================================================================
    // Next-state logic.
    // ======================================================================

    // Edges are found on the second and third synchroniser stages only.
    always_comb begin
        st_next = st_reg;
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], spi_sclk};
        st_next.cs_sync = {st_reg.cs_sync[1:0], spi_cs_n};
        st_next.mosi_sync = {st_reg.mosi_sync[0], spi_mosi};
        sclk_rise = st_reg.sclk_sync[1] & ~st_reg.sclk_sync[2];
        sclk_fall = ~st_reg.sclk_sync[1] & st_reg.sclk_sync[2];
        cs_fall = ~st_reg.cs_sync[1] & st_reg.cs_sync[2];
        cs_rise = st_reg.cs_sync[1] & ~st_reg.cs_sync[2];
        // A short or long frame is dropped whole rather than half applied.
        frame_ok = (st_reg.phase == LPA_COMMIT) && (st_reg.bit_cnt == `LPA_FRAME_BITS);
        sleep_cmd_ok = frame_ok && st_reg.rx.wr && !st_reg.sleep
            && (st_reg.rx.addr == `LPA_ADDR_SLEEP)
            && (st_reg.rx.data == `LPA_SLEEP_PATTERN);
        masked_state = switch_state & ~st_reg.route;
        if (st_reg.wake_pend) begin
            tx_load = {8'h00, 1'b1, 1'b1, masked_state};
        end else begin
            tx_load = {8'h00, st_reg.reply_next};
        end

        case (st_reg.phase)
            LPA_IDLE: begin
                if (cs_fall) begin
                    st_next.phase = LPA_SHIFT;
                    st_next.bit_cnt = '0;
                    st_next.tx = tx_load;
                    st_next.miso = tx_load[31];
                    st_next.miso_oe_n = 1'b0;
                    st_next.wake_pend = 1'b0;
                end
            end
            LPA_SHIFT: begin
                if (cs_rise) begin
                    st_next.phase = LPA_COMMIT;
                    st_next.miso_oe_n = 1'b1;
                end else begin
                    // Bits beyond the 32nd still shift, but mark the frame bad.
                    if (sclk_rise) begin
                        st_next.rx = {st_reg.rx[30:0], st_reg.mosi_sync[1]};
                        if (st_reg.bit_cnt != 6'h3F) begin
                            st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
                        end
                    end
                    if (sclk_fall && (st_reg.bit_cnt != 6'h00)) begin
                        st_next.tx = {st_reg.tx[30:0], 1'b0};
                        st_next.miso = st_reg.tx[30];
                    end
                end
            end
            LPA_COMMIT: begin
                st_next.phase = LPA_IDLE;
                // Writes are taken only in normal mode, so sleep never
                // disturbs what software programmed.
                if (frame_ok && st_reg.rx.wr && !st_reg.sleep) begin
                    case (st_reg.rx.addr)
                        `LPA_ADDR_PROG_POLL: begin
                            st_next.cfg.prog_poll = st_reg.rx.data[`LPA_PROG_CH-1:0];
                        end
                        `LPA_ADDR_GND_POLL: begin
                            st_next.cfg.gnd_poll = st_reg.rx.data[`LPA_GND_CH-1:0];
                        end
                        `LPA_ADDR_ANALOG: begin
                            st_next.cfg.analog_code = st_reg.rx.data[`LPA_CODE_BITS-1:0];
                            st_next.cfg.analog_src = st_reg.rx.data[`LPA_ANALOG_SRC_BIT];
                        end
                        default: begin
                        end
                    endcase
                end
                if (sleep_cmd_ok) begin
                    st_next.sleep = 1'b1;
                end
                // Reply for the next frame: flags on top, unused bits zero.
                st_next.reply_next.fault = fault_summary;
                st_next.reply_next.event_flag = event_flag;
                case (st_reg.rx.addr)
                    `LPA_ADDR_PROG_POLL: begin
                        st_next.reply_next.data = {14'h0000, st_next.cfg.prog_poll};
                    end
                    `LPA_ADDR_GND_POLL: begin
                        st_next.reply_next.data = {8'h00, st_next.cfg.gnd_poll};
                    end
                    `LPA_ADDR_ANALOG: begin
                        st_next.reply_next.data = {15'h0000, st_next.cfg.analog_src,
                            st_next.cfg.analog_code};
                    end
                    default: begin
                        st_next.reply_next.data = masked_state;
                    end
                endcase
                // The sleep command carries no meaningful reply.
                if (st_reg.rx.wr && (st_reg.rx.addr == `LPA_ADDR_SLEEP)) begin
                    st_next.reply_next = '0;
                end
                if (!frame_ok) begin
                    st_next.reply_next = st_reg.reply_next;
                end
            end
            default: begin
                st_next.phase = LPA_IDLE;
                st_next.miso_oe_n = 1'b1;
            end
        endcase

        // Wake is handled last so a wake in the same cycle as a frame start
        // still flags the following frame: the set wins over the clear.
        if (wake_request && st_reg.sleep) begin
            st_next.sleep = 1'b0;
            st_next.wake_pend = 1'b1;
        end

        // Derived outputs, all registered.
        st_next.route = route_of(st_next.cfg.analog_code);
        st_next.poll_wet = {st_next.cfg.prog_poll, st_next.cfg.gnd_poll};
        st_next.analog_wet = st_next.cfg.analog_src && (st_next.route != '0);
    end

    // ======================================================================
    // State register.
    // ======================================================================

    // Chip-select stages reset high so release never looks like a frame start.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.cs_sync <= 3'h7;
            st_reg.miso_oe_n <= 1'b1;
            st_reg.phase <= LPA_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // Outputs, each straight from the state register.
    // ======================================================================
    assign spi_miso = st_reg.miso;
    assign spi_miso_oe_n = st_reg.miso_oe_n;
    assign sleep_mode = st_reg.sleep;
    assign poll_use_wetting = st_reg.poll_wet;
    assign analog_route = st_reg.route;
    assign analog_code = st_reg.cfg.analog_code;
    assign analog_wet_drive = st_reg.analog_wet;

    // ======================================================================
    // Checks.
    // ======================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_reset_clears_cfg: assert property ($fell(reset) |-> (st_reg.cfg == '0 && !st_reg.sleep))
        else $error("configuration not zero after reset");

    chk_sleep_only_cmd: assert property ($rose(st_reg.sleep) |-> $past(sleep_cmd_ok))
        else $error("sleep entered without a valid command");

    chk_sleep_bad_data: assert property ((frame_ok && st_reg.rx.addr == `LPA_ADDR_SLEEP
        && st_reg.rx.data != `LPA_SLEEP_PATTERN && !st_reg.sleep) |=> !st_reg.sleep)
        else $error("sleep entered on nonzero data");

    chk_sleep_keeps_cfg: assert property (st_reg.sleep |=> $stable(st_reg.cfg))
        else $error("configuration changed in sleep");

    chk_route_one_hot: assert property ($onehot0(st_reg.route))
        else $error("more than one input routed");

    chk_route_code_map: assert property ((st_reg.cfg.analog_code == `LPA_CODE_PROG_FIRST)
        |-> (st_reg.route[`LPA_GND_CH] && !st_reg.route[`LPA_GND_CH-1]))
        else $error("first programmable code routed wrong");

    chk_wake_reply_flags: assert property ((st_reg.phase == LPA_IDLE && cs_fall && st_reg.wake_pend)
        |=> (st_reg.tx[23:22] == 2'b11 && st_reg.phase == LPA_SHIFT && !st_reg.wake_pend))
        else $error("first reply after wake lacks flags");

    chk_wake_reply_mask: assert property ((st_reg.phase == LPA_IDLE && cs_fall && st_reg.wake_pend)
        |=> ((st_reg.tx[21:0] & st_reg.route) == '0))
        else $error("routed input not reported as zero");

    chk_poll_follows_cfg: assert property ($stable(st_reg.cfg) [*2]
        |-> st_reg.poll_wet == {st_reg.cfg.prog_poll, st_reg.cfg.gnd_poll})
        else $error("polling select output disagrees");

    chk_unused_read_zero: assert property ((frame_ok && st_reg.rx.addr == `LPA_ADDR_PROG_POLL)
        |=> st_reg.reply_next.data[21:8] == '0)
        else $error("unused bits read back nonzero");

    chk_miso_released: assert property ((st_reg.phase == LPA_SHIFT && cs_rise)
        |=> (st_reg.miso_oe_n && st_reg.phase == LPA_COMMIT) ##1 st_reg.phase == LPA_IDLE)
        else $error("reply pin not released after frame");

    // ======================================================================
    // Checks on writes, routing, wake, replies and the link pins.
    // ======================================================================

    // A good write lands whole in its field.
    chk_prog_poll_write: assert property ((frame_ok && st_reg.rx.wr && !st_reg.sleep
        && st_reg.rx.addr == `LPA_ADDR_PROG_POLL) |=> st_reg.cfg.prog_poll == $past(st_reg.rx.data[7:0]))
        else $error("programmable select write lost");

    // Ground select keeps bits 13 to 0 only.
    chk_gnd_poll_write: assert property ((frame_ok && st_reg.rx.wr && !st_reg.sleep
        && st_reg.rx.addr == `LPA_ADDR_GND_POLL) |=> st_reg.cfg.gnd_poll == $past(st_reg.rx.data[13:0]))
        else $error("ground select write lost");

    // Source bit and channel code land together.
    chk_analog_write: assert property ((frame_ok && st_reg.rx.wr && !st_reg.sleep
        && st_reg.rx.addr == `LPA_ADDR_ANALOG) |=> {st_reg.cfg.analog_src, st_reg.cfg.analog_code}
        == $past(st_reg.rx.data[6:0]))
        else $error("analog select write lost");

    // A cut frame changes neither the settings nor the waiting reply.
    chk_short_frame_drop: assert property ((st_reg.phase == LPA_COMMIT && !frame_ok)
        |=> ($stable(st_reg.cfg) && $stable(st_reg.reply_next)))
        else $error("cut frame was applied");

    // Code zero and the undefined codes route nothing.
    chk_route_none: assert property ((st_reg.cfg.analog_code == `LPA_CODE_NONE
        || st_reg.cfg.analog_code > `LPA_CODE_PROG_LAST) |-> st_reg.route == '0)
        else $error("undefined code routed an input");

    // Code one is ground input 0.
    chk_route_gnd_first: assert property ((st_reg.cfg.analog_code == `LPA_CODE_GND_FIRST)
        |-> st_reg.route == 22'h000001)
        else $error("first ground code routed wrong");

    // The last code is programmable input 7.
    chk_route_prog_last: assert property ((st_reg.cfg.analog_code == `LPA_CODE_PROG_LAST)
        |-> st_reg.route == 22'h200000)
        else $error("last programmable code routed wrong");

    // A wake leaves sleep at once and flags the next reply.
    chk_wake_leaves_sleep: assert property ((wake_request && st_reg.sleep)
        |=> (!st_reg.sleep && st_reg.wake_pend))
        else $error("wake did not leave sleep");

    // The sleep command queues an all-zero reply word.
    chk_sleep_reply_zero: assert property ((frame_ok && st_reg.rx.wr
        && st_reg.rx.addr == `LPA_ADDR_SLEEP) |=> st_reg.reply_next == '0)
        else $error("sleep command reply not zero");

    // Both flags are sampled at commit for every other good frame.
    chk_reply_flags: assert property ((frame_ok && !(st_reg.rx.wr
        && st_reg.rx.addr == `LPA_ADDR_SLEEP)) |=> (st_reg.reply_next.fault == $past(fault_summary)
        && st_reg.reply_next.event_flag == $past(event_flag)))
        else $error("reply flags not sampled at commit");

    // Ground readback carries no bits above 13.
    chk_gnd_read_zero: assert property ((frame_ok && st_reg.rx.addr == `LPA_ADDR_GND_POLL)
        |=> st_reg.reply_next.data[21:14] == '0)
        else $error("unused ground bits read back nonzero");

    // The reply pin is driven through the whole frame.
    chk_oe_in_frame: assert property ((st_reg.phase == LPA_SHIFT)
        |-> !st_reg.miso_oe_n)
        else $error("reply pin released inside a frame");

    // Upper reply bits are zero and the first bit is out at once.
    chk_tx_first_bit: assert property ((st_reg.phase == LPA_IDLE && cs_fall)
        |=> (st_reg.tx[31:24] == 8'h00 && st_reg.miso == st_reg.tx[31]))
        else $error("reply word loaded wrong");

endmodule

// ==== lpa_host_model.sv ====
/*
 * Behavioural host model: a link master in mode 0 that sends 32-bit frames
 * most significant bit first and captures the reply word.
 * Assumes the bench calls xfer from one process at a time.
 */
`timescale 1ns/10ps

module lpa_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n
);
    // Half period of the 160 ns link clock; hold_extra slows the host down.
    localparam time HALF = 80ns;
    time hold_extra;
    logic oe_mid;

    // Idle pins: clock parked low, select high.
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        hold_extra = 0;
        oe_mid = 1'b1;
    end

    // ======================================================================
    // One frame; a short count is used only to provoke a refusal.
    // ======================================================================
    task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [31:0] rsp);
        rsp = 32'h00000000;
        spi_cs_n = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            spi_mosi = cmd[i];
            #(HALF + hold_extra);
            spi_sclk = 1'b1;
            // A released reply line is taken as the inverse, so a late enable shows up.
            rsp = {rsp[30:0], spi_miso_oe_n ? ~spi_miso : spi_miso};
            if (i == 31) oe_mid = spi_miso_oe_n;
            #(HALF + hold_extra);
            spi_sclk = 1'b0;
        end
        spi_cs_n = 1'b1;
        // A released data line keeps no value, so show the inverse of the last bit.
        spi_mosi = ~spi_mosi;
        #(2 * HALF);
    endtask
endmodule

// ==== tb_lpm_polling_analog_monitor_output_config.sv ====
/*
 * Self-checking bench: drives the block through the host model and
 * compares every 32-bit frame's reply and every output with a reference model.
 * Assumes the block answers frame N in frame N+1 and commits within 12 clk.
 */
`timescale 1ns/10ps
`include "lpa_defines.svh"

module tb_lpm_polling_analog_monitor_output_config;
    import lpa_pkg::*;
    logic clk = 1'b0, reset = 1'b1, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic [21:0] switch_state = 22'h000000, poll_use_wetting, analog_route;
    logic fault_summary = 1'b0, event_flag = 1'b0, wake_request = 1'b0;
    logic sleep_mode, analog_wet_drive;
    logic [5:0] analog_code;
    logic [7:0] m_prog = 8'h00;
    logic [13:0] m_gnd = 14'h0000;
    logic [5:0] m_code = 6'h00;
    logic m_src = 1'b0, m_sleep = 1'b0, m_wake = 1'b0;
    logic [31:0] m_reply = 32'h00000000;
    logic [6:0] addrs [5] = '{7'h16, 7'h17, 7'h1D, 7'h1F, 7'h05};
    int mismatches = 0, cmp_count = 0;

    // 200 MHz clock.
    always #2.5 clk = ~clk;

    lpa_config dut_u (.clk(clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
        .switch_state(switch_state), .fault_summary(fault_summary), .event_flag(event_flag),
        .wake_request(wake_request), .sleep_mode(sleep_mode), .poll_use_wetting(poll_use_wetting),
        .analog_route(analog_route), .analog_code(analog_code), .analog_wet_drive(analog_wet_drive));
    lpa_host_model host_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

    // ======================================================================
    // Reference model helpers and comparisons.
    // ======================================================================
    function automatic logic [21:0] route_of(input logic [5:0] c);
        return (c >= 6'h01 && c <= 6'h16) ? 22'h000001 << (c - 6'h01) : 22'h000000;
    endfunction

    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_port(input string n, input logic [21:0] e, input logic [21:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Inputs always change 1 ns after the rising edge.
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic check_outputs();
        cmp_port("sleep_mode", 22'(m_sleep), 22'(sleep_mode));
        cmp_port("poll_use_wetting", {m_prog, m_gnd}, poll_use_wetting);
        cmp_port("analog_route", route_of(m_code), analog_route);
        cmp_port("analog_code", 22'(m_code), 22'(analog_code));
        cmp_port("analog_wet_drive", 22'(m_src && route_of(m_code) != 0), 22'(analog_wet_drive));
        cmp_port("miso_oe_n idle", 22'h000001, 22'(spi_miso_oe_n));
    endtask

    // One frame: predict the reply, run it, then apply the commit to the model.
    task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] d, input int nb);
        logic [31:0] rsp;
        step();
        switch_state = 22'($urandom);
        fault_summary = 1'($urandom);
        event_flag = 1'($urandom);
        if (m_wake) m_reply = {8'h00, 2'b11, switch_state & ~route_of(m_code)};
        m_wake = 1'b0;
        host_u.xfer({a, w, d}, nb, rsp);
        cmp_port("miso_oe_n frame", 22'h000000, 22'(host_u.oe_mid));
        if (nb == 32) begin
            cmp_word("reply", m_reply, rsp);
            if (w && !m_sleep) begin
                if (a == `LPA_ADDR_PROG_POLL) m_prog = d[7:0];
                if (a == `LPA_ADDR_GND_POLL) m_gnd = d[13:0];
                if (a == `LPA_ADDR_ANALOG) {m_src, m_code} = d[6:0];
                if (a == `LPA_ADDR_SLEEP && d == `LPA_SLEEP_PATTERN) m_sleep = 1'b1;
            end
            m_reply = {8'h00, fault_summary, event_flag, switch_state & ~route_of(m_code)};
            if (a == `LPA_ADDR_PROG_POLL) m_reply[21:0] = {14'h0000, m_prog};
            if (a == `LPA_ADDR_GND_POLL) m_reply[21:0] = {8'h00, m_gnd};
            if (a == `LPA_ADDR_ANALOG) m_reply[21:0] = {15'h0000, m_src, m_code};
            if (w && a == `LPA_ADDR_SLEEP) m_reply = 32'h00000000;
        end
        repeat (12) step();
        check_outputs();
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog a fifth above the expected 395 us of traffic, under 100,000 clocks.
    initial begin
        #470us;
        mismatches++;
        close_out();
    end

    // ======================================================================
    // Main sequence.
    // ======================================================================
    initial begin
        void'($urandom(82031));
        repeat (12) step();
        reset = 1'b0;
        repeat (4) step();
        check_outputs();
        // Reset readback of every register.
        frame(7'h16, 1'b0, 24'h000000, 32);
        frame(7'h17, 1'b0, 24'h000000, 32);
        frame(7'h1D, 1'b0, 24'h000000, 32);
        // Every channel code plus one undefined, each followed by a status read.
        for (int c = 0; c < 24; c++) begin
            frame(7'h1D, 1'b1, {17'($urandom), 1'($urandom), 6'(c)}, 32);
            frame(7'h1F, 1'b0, 24'($urandom), 32);
        end
        // Random traffic from a slow host over mapped and unmapped places.
        host_u.hold_extra = 40ns;
        for (int i = 0; i < 10; i++) begin
            frame(addrs[$urandom % 5], 1'($urandom), 24'($urandom), 32);
        end
        host_u.hold_extra = 0;
        // A short frame must leave registers and the pending reply alone.
        frame(7'h16, 1'b1, 24'($urandom), 31);
        frame(7'h16, 1'b0, 24'h000000, 32);
        // Sleep: bad pattern refused, good one taken, writes in sleep dropped, then wake.
        frame(7'h1C, 1'b1, 24'h000100, 32);
        frame(7'h1C, 1'b1, 24'h000000, 32);
        frame(7'h1D, 1'b1, 24'h000045, 32);
        step();
        wake_request = 1'b1;
        m_sleep = 1'b0;
        m_wake = 1'b1;
        step();
        wake_request = 1'b0;
        repeat (3) step();
        check_outputs();
        frame(7'h17, 1'b0, 24'h000000, 32);
        frame(7'h1F, 1'b0, 24'h000000, 32);
        // A reset in mid-run clears every setting and the pending reply.
        reset = 1'b1;
        repeat (3) step();
        reset = 1'b0;
        {m_prog, m_gnd, m_src, m_code, m_reply} = 61'h0;
        repeat (4) step();
        check_outputs();
        frame(7'h1D, 1'b0, 24'h000000, 32);
        close_out();
    end
endmodule
